// file: rtl/pscs_pkg.sv
// pscs_pkg: constants, register map and lookup functions of the channel sequencer.
// assumes a single 20 MHz clock and a plain strobe register port.
package pscs_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_HZ       = 20_000_000;
  localparam int TICK_HZ      = 50_000;
  localparam int TICK_DIV     = CLK_HZ / TICK_HZ;
  localparam int TICK_DIV_W   = 9;
  localparam logic [TICK_DIV_W-1:0] TICK_DIV_V = TICK_DIV_W'(TICK_DIV);
  localparam int STEP_US      = 20;
  localparam int WIDTH_MIN_US = 20;
  localparam int WIDTH_MAX_US = 2000;
  localparam logic [6:0] WSEL_MIN = 7'(WIDTH_MIN_US / STEP_US);
  localparam logic [6:0] WSEL_MAX = 7'(WIDTH_MAX_US / STEP_US);
  localparam int MS_PER_S     = 1000;
  localparam int MS_TICKS     = TICK_HZ / MS_PER_S;
  localparam int MS_W         = 6;
  localparam logic [3:0] REP_MIN_HZ = 4'h1;
  localparam logic [3:0] REP_MAX_HZ = 4'ha;
  localparam int REP_W        = 10;

  // ==========================================================
  // channels and operation counter
  localparam int NCH          = 11;
  localparam int OPS_W        = 10;
  localparam logic [1:0] OPS_SEL_1000 = 2'h0;
  localparam logic [1:0] OPS_SEL_100  = 2'h1;
  localparam logic [1:0] OPS_SEL_10   = 2'h2;

  // ==========================================================
  // register map
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_CFG   = 8'h04;
  localparam logic [7:0] REG_DELAY = 8'h08;
  localparam logic [7:0] REG_OPS   = 8'h0c;
  localparam logic [7:0] REG_CNT0  = 8'h10;
  localparam int CTRL_INIT_BIT  = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CFG_WSEL_LSB   = 0;
  localparam int CFG_OPS_LSB    = 8;
  localparam int CFG_REP_LSB    = 12;

  // ==========================================================
  // values after reset
  localparam logic [6:0] WSEL_RST    = WSEL_MAX;
  localparam logic [1:0] OPS_SEL_RST = OPS_SEL_1000;
  localparam logic [3:0] REP_HZ_RST  = REP_MAX_HZ;
  localparam int         DLY_RST     = 10;

  // ==========================================================
  // lookups
  function automatic logic [OPS_W-1:0] ops_target(input logic [1:0] sel);
    logic [OPS_W-1:0] t;
    t = OPS_W'(1000);
    case (sel)
      OPS_SEL_100: t = OPS_W'(100);
      OPS_SEL_10:  t = OPS_W'(10);
      default:     t = OPS_W'(1000);
    endcase
    return t;
  endfunction

  function automatic logic [REP_W-1:0] rep_period_ms(input logic [3:0] hz);
    logic [REP_W-1:0] p;
    p = REP_W'(MS_PER_S / 10);
    case (hz)
      4'h1:    p = REP_W'(MS_PER_S / 1);
      4'h2:    p = REP_W'(MS_PER_S / 2);
      4'h3:    p = REP_W'(MS_PER_S / 3);
      4'h4:    p = REP_W'(MS_PER_S / 4);
      4'h5:    p = REP_W'(MS_PER_S / 5);
      4'h6:    p = REP_W'(MS_PER_S / 6);
      4'h7:    p = REP_W'(MS_PER_S / 7);
      4'h8:    p = REP_W'(MS_PER_S / 8);
      4'h9:    p = REP_W'(MS_PER_S / 9);
      default: p = REP_W'(MS_PER_S / 10);
    endcase
    return p;
  endfunction

endpackage

// file: rtl/pscs_pulse_div.sv
// pscs_pulse_div: counts enable pulses and emits one pulse every div of them.
// assumes en is on mclk, one count per cycle it is high; div of zero acts as one.
module pscs_pulse_div import pscs_pkg::*; #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         srst,
  // rate
  input  wire logic         en,
  input  wire logic [W-1:0] div,
  // output
  output logic              pulse
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pulse;
  } pscs_div_t;

  pscs_div_t q;
  pscs_div_t next_q;

  always_comb begin
    next_q       = q;
    next_q.pulse = 1'b0;
    if (srst) begin
      next_q = '0;
    end else if (en) begin
      if (({1'b0, q.cnt} + (W+1)'(1)) >= {1'b0, div}) begin
        next_q.cnt   = '0;
        next_q.pulse = 1'b1;
      end else begin
        next_q.cnt = W'(q.cnt + W'(1));
      end
    end
  end

  always_ff @(posedge mclk) begin
    q <= next_q;
  end

  assign pulse = q.pulse;

endmodule

// file: rtl/pscs_seq.sv
// pscs_seq: pulsed source channel sequencer with eleven gated counting channels.
// assumes detector pulses synchronous to mclk and a strobe register port.
//
// What this block does
// - eleven counters, one background and ten equal adjacent decay slots.
// - base tick at fifty kilohertz derived from the clock.
// - slot divider gives pulses every 20 to 2000 us in 20 us steps.
// - usable width 20 to 2000 us; all eleven channels share one width.
// - repetition source starts cycles between one and ten times per second.
// - background count lasts exactly one channel width.
// - background taken just before trigger, same width as decay channels.
// - trigger issued once per cycle after background, by this block.
// - after trigger and delay, decay channels gated in turn, one width each.
// - cycle end resets sequencing and bumps operation counter, target 10/100/1000.
// - after target operations, cycling stops and counts are held.
// - default target is a thousand cycles.
// - initialization clears sequencing flops except first ring stage, which sets.
// - initialization zeroes operation counter and loads the delay preset.
// - repetition pulse sets latch; its rising edge sets armed flop.
// - next tick sets background window if armed, gate open, not busy.
// - busy sets with background window; window one tick; pre-trigger follows.
// - next tick counts delay once, pre-trigger clears, fire sets; edge triggers.
// - after N-1 ticks fire clears, monitor sets; ticks then walk the ring.
// - ring wrap clears busy, monitor, latch; counts op; target disarms gate.
//
// The implementer's own choices: strobed register access and the register offsets.
module pscs_seq import pscs_pkg::*; #(
  parameter int CNT_W        = 20,
  parameter int DLY_W        = 12,
  parameter int TICKS_PER_MS = MS_TICKS
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     srst,
  // register port
  input  wire logic [7:0]               addr,
  input  wire logic [31:0]              wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic      [31:0]              rdata,
  // detector side
  input  wire logic                     count_in,
  // source and channel side
  output logic                          pulsed_source_trigger,
  output logic      [NCH-1:0]           chan_gate,
  output logic                          busy,
  output logic                          done
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0]                rdata;
    logic                       trig;
    logic [NCH-1:0]             gate;
    logic [NCH-1:0][CNT_W-1:0]  cnt;
    logic [2:0]                 sync;
    logic [6:0]                 wsel;
    logic [6:0]                 wsel_req;
    logic [1:0]                 ops_sel;
    logic [3:0]                 rep_hz;
    logic [DLY_W-1:0]           cfg_dly;
    logic [DLY_W-1:0]           dly_preset;
    logic [DLY_W-1:0]           dly;
    logic [REP_W-1:0]           rep_ms;
    logic [OPS_W-1:0]           ops;
    logic                       done;
    logic                       start_gate;
    logic                       rep_latch;
    logic                       rep_latch_d;
    logic                       armed;
    logic                       bg_win;
    logic                       cyc_busy;
    logic                       pre_trig;
    logic                       fire;
    logic                       mon_en;
    logic [NCH-1:0]             ring;
  } pscs_seq_t;

  pscs_seq_t q;
  pscs_seq_t next_q;

  // ==========================================================
  // time bases
  logic base_tick;
  logic slot_tick;
  logic ms_tick;

  // base tick at 50 kHz from the system clock
  pscs_pulse_div #(.W(TICK_DIV_W)) u_base (
    .mclk  (mclk),
    .srst  (srst),
    .en    (1'b1),
    .div   (TICK_DIV_V),
    .pulse (base_tick)
  );

  // channel width: one slot pulse per wsel base ticks
  pscs_pulse_div #(.W(7)) u_slot (
    .mclk  (mclk),
    .srst  (srst),
    .en    (base_tick),
    .div   (q.wsel),
    .pulse (slot_tick)
  );

  // millisecond prescaler for the repetition source
  pscs_pulse_div #(.W(MS_W)) u_ms (
    .mclk  (mclk),
    .srst  (srst),
    .en    (base_tick),
    .div   (MS_W'(TICKS_PER_MS)),
    .pulse (ms_tick)
  );

  // ==========================================================
  // next state
  logic             det_edge;
  logic [6:0]       wsel_wr;
  logic [3:0]       rep_wr;
  logic [OPS_W-1:0] ops_inc;
  logic [7:0]       cnt_off;
  logic             cyc_start;
  logic             ring_wrap;

  logic [NCH-1:0]            chan_inc;
  logic [NCH-1:0]            chan_rsel;
  logic [NCH-1:0][CNT_W-1:0] chan_next;

  // first stage feeds only the second; edge taken past it
  assign det_edge = q.sync[1] & ~q.sync[2];
  assign cnt_off  = 8'(addr - REG_CNT0);

  // cycle start and ring wrap, both taken on a slot tick
  assign cyc_start = slot_tick & q.armed & q.start_gate & ~q.cyc_busy;
  assign ring_wrap = slot_tick & q.mon_en & q.ring[NCH-1];

  // ==========================================================
  // per-channel decode, one copy per counter
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    // counting only in the open window keeps idle pulses out
    assign chan_inc[g]  = det_edge & q.gate[g];
    assign chan_rsel[g] = (addr >= REG_CNT0) && (cnt_off == 8'(4 * g));
    // plain wrap; the width holds a full run of counts
    assign chan_next[g] = CNT_W'(q.cnt[g] + CNT_W'(1));
  end

  always_comb begin
    next_q      = q;
    next_q.rdata = '0;
    next_q.trig = 1'b0;
    wsel_wr     = wdata[CFG_WSEL_LSB +: 7];
    rep_wr      = wdata[CFG_REP_LSB +: 4];
    ops_inc     = OPS_W'(q.ops + OPS_W'(1));

    next_q.sync = {q.sync[1:0], count_in};

    // ========================================================
    // register reads, data valid in the following cycle
    if (rd) begin
      unique case (addr)
        REG_CTRL:  next_q.rdata = {28'h0000000, q.mon_en, q.cyc_busy, q.start_gate, q.done};
        REG_CFG:   next_q.rdata = {16'h0000, q.rep_hz, 2'h0, q.ops_sel, 1'b0, q.wsel_req};
        REG_DELAY: next_q.rdata = 32'(q.dly_preset);
        REG_OPS:   next_q.rdata = 32'(q.ops);
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (chan_rsel[i]) begin
              next_q.rdata = 32'(q.cnt[i]);
            end
          end
        end
      endcase
    end

    // ========================================================
    // configuration writes; out of range width and rate values are clamped
    if (wr && addr == REG_CFG) begin
      if (wsel_wr < WSEL_MIN) begin
        next_q.wsel_req = WSEL_MIN;
      end else if (wsel_wr > WSEL_MAX) begin
        next_q.wsel_req = WSEL_MAX;
      end else begin
        next_q.wsel_req = wsel_wr;
      end
      next_q.ops_sel = wdata[CFG_OPS_LSB +: 2];
      if (rep_wr < REP_MIN_HZ) begin
        next_q.rep_hz = REP_MIN_HZ;
      end else if (rep_wr > REP_MAX_HZ) begin
        next_q.rep_hz = REP_MAX_HZ;
      end else begin
        next_q.rep_hz = rep_wr;
      end
    end
    if (wr && addr == REG_DELAY) begin
      // takes effect at the next initialization only
      next_q.cfg_dly = wdata[DLY_W-1:0];
    end

    // width changes wait for an idle sequencer so a cycle never mixes widths
    if (!q.cyc_busy) begin
      next_q.wsel = q.wsel_req;
    end

    // ========================================================
    // channel counting, gated by the registered gate vector
    for (int i = 0; i < NCH; i++) begin
      if (chan_inc[i]) begin
        next_q.cnt[i] = chan_next[i];
      end
    end

    // ========================================================
    // repetition latch rising edge arms the cycle
    next_q.rep_latch_d = q.rep_latch;
    if (q.rep_latch && !q.rep_latch_d) begin
      next_q.armed = 1'b1;
    end

    // ========================================================
    // sequencer, advanced on each slot tick
    if (slot_tick) begin
      if (cyc_start) begin
        next_q.bg_win   = 1'b1;
        next_q.cyc_busy = 1'b1;
        next_q.armed    = 1'b0;
      end
      if (q.bg_win) begin
        // window is exactly one slot, then the trigger is prepared
        next_q.bg_win   = 1'b0;
        next_q.pre_trig = 1'b1;
      end
      if (q.pre_trig) begin
        next_q.pre_trig = 1'b0;
        next_q.fire     = 1'b1;
        // a zero preset must not wrap round to the longest delay
        if (q.dly_preset == '0) begin
          next_q.dly = '0;
        end else begin
          next_q.dly = DLY_W'(q.dly_preset - DLY_W'(1));
        end
      end
      if (q.fire) begin
        // a preset of 0 or 1 behaves as the shortest delay
        if (q.dly <= DLY_W'(1)) begin
          next_q.fire   = 1'b0;
          next_q.mon_en = 1'b1;
        end else begin
          next_q.dly = DLY_W'(q.dly - DLY_W'(1));
        end
      end
      if (q.mon_en) begin
        next_q.ring = {q.ring[NCH-2:0], q.ring[NCH-1]};
        if (ring_wrap) begin
          next_q.cyc_busy  = 1'b0;
          next_q.mon_en    = 1'b0;
          next_q.rep_latch = 1'b0;
          next_q.ops       = ops_inc;
          if (ops_inc >= ops_target(q.ops_sel)) begin
            next_q.start_gate = 1'b0;
            next_q.done       = 1'b1;
          end
        end
      end
    end

    // ========================================================
    // repetition oscillator; a new pulse beats a same-cycle ring-wrap clear
    if (ms_tick) begin
      if ((q.rep_ms + REP_W'(1)) >= rep_period_ms(q.rep_hz)) begin
        next_q.rep_ms    = '0;
        next_q.rep_latch = 1'b1;
      end else begin
        next_q.rep_ms = REP_W'(q.rep_ms + REP_W'(1));
      end
    end

    // the trigger is one clock long, on the fire flop's rising edge
    next_q.trig = next_q.fire & ~q.fire;

    // ========================================================
    // commands: initialization first, then start
    if (wr && addr == REG_CTRL && wdata[CTRL_INIT_BIT]) begin
      next_q.start_gate  = 1'b0;
      next_q.rep_latch   = 1'b0;
      next_q.rep_latch_d = 1'b0;
      next_q.armed       = 1'b0;
      next_q.bg_win      = 1'b0;
      next_q.cyc_busy    = 1'b0;
      next_q.pre_trig    = 1'b0;
      next_q.fire        = 1'b0;
      next_q.mon_en      = 1'b0;
      next_q.ring        = NCH'(1);
      next_q.ops         = '0;
      next_q.done        = 1'b0;
      next_q.dly_preset  = q.cfg_dly;
      next_q.dly         = q.cfg_dly;
      next_q.cnt         = '0;
      next_q.trig        = 1'b0;
    end
    if (wr && addr == REG_CTRL && wdata[CTRL_START_BIT] && !next_q.done) begin
      // a finished run must be reinitialized before it can restart
      next_q.start_gate = 1'b1;
    end

    // gate vector: background window then the decay ring stages
    next_q.gate = {next_q.ring[NCH-1:1] & {(NCH-1){next_q.mon_en}}, next_q.bg_win};

    // ========================================================
    // synchronous reset
    if (srst) begin
      next_q            = '0;
      next_q.ring       = NCH'(1);
      next_q.wsel       = WSEL_RST;
      next_q.wsel_req   = WSEL_RST;
      next_q.ops_sel    = OPS_SEL_RST;
      next_q.rep_hz     = REP_HZ_RST;
      next_q.cfg_dly    = DLY_W'(DLY_RST);
      next_q.dly_preset = DLY_W'(DLY_RST);
      next_q.dly        = DLY_W'(DLY_RST);
    end
  end

  always_ff @(posedge mclk) begin
    q <= next_q;
  end

  // ==========================================================
  // outputs, all straight from flops
  assign rdata                 = q.rdata;
  assign pulsed_source_trigger = q.trig;
  assign chan_gate             = q.gate;
  assign busy                  = q.cyc_busy;
  assign done                  = q.done;

endmodule

// file: verif/pscs_seq_props.sv
// pscs_seq_props: port-level checks of the channel sequencer.
// assumes a bind onto pscs_seq, one mclk domain, srst synchronous high.
module pscs_seq_props import pscs_pkg::*; (
  // clock and reset
  input wire logic           mclk,
  input wire logic           srst,
  // sequence outputs
  input wire logic           pulsed_source_trigger,
  input wire logic [NCH-1:0] chan_gate,
  input wire logic           busy,
  input wire logic           done
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========
  // helpers: run length of each gate pattern
  logic [NCH-1:0] prev;
  logic [15:0]    run;
  logic [15:0]    wid;
  logic           fired;

  // width is learnt from the background slot, so any width select works
  always_ff @(posedge mclk) begin
    if (srst) begin
      prev  <= '0;
      run   <= '0;
      wid   <= '0;
      fired <= 1'b0;
    end else begin
      prev  <= chan_gate;
      run   <= (chan_gate != prev) ? 16'h0001 : run + 16'h0001;
      fired <= busy && (fired || pulsed_source_trigger);
      if (prev == 11'h001 && chan_gate == '0) begin
        wid <= run;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // ==========
  // assertions
  a_gate_onehot: assert property ($onehot0(chan_gate))
    else $error("two gates open at once");
  a_ring_order: assert property ((chan_gate != prev && prev > 11'h001)
    |-> chan_gate == (prev << 1)) else $error("decay ring out of order");
  a_equal_width: assert property ((chan_gate != prev && prev > 11'h001)
    |-> run == wid) else $error("decay slot width differs from background");
  a_pretrig_slot: assert property (pulsed_source_trigger
    |-> chan_gate == '0 && prev == '0 && run == wid) else $error("trigger not one slot late");
  a_trig_once: assert property (pulsed_source_trigger |-> busy && !fired)
    else $error("trigger outside cycle or repeated");
  a_trig_pulse: assert property (pulsed_source_trigger |=> !pulsed_source_trigger)
    else $error("trigger longer than one clock");
  a_bg_start: assert property ($rose(chan_gate[0]) |-> $rose(busy) && !done)
    else $error("background without busy rising");
  a_idle_gates: assert property (!busy |-> chan_gate == '0)
    else $error("gate open while idle");
  a_wrap_clears: assert property ($fell(chan_gate[10]) |-> $fell(busy) && chan_gate == '0)
    else $error("busy not cleared at ring wrap");
  a_monitor_after: assert property ($rose(chan_gate[1]) |-> fired && $past(chan_gate) == '0)
    else $error("decay slots began before trigger");

  c_bg_seen: cover property ($rose(chan_gate[0]));
  c_trig_seen: cover property (pulsed_source_trigger);
  c_wrap_seen: cover property ($fell(chan_gate[10]));
endmodule

// file: verif/pscs_det_model.sv
// pscs_det_model: detector pulse source and trigger receiver.
// assumes mclk from the bench; pulses are made only while en is high.
module pscs_det_model #(
  parameter int PER = 40
) (
  // clock and control
  input  wire logic       mclk,
  input  wire logic       en,
  // device pins
  input  wire logic       pulsed_source_trigger,
  output logic            count_in = 1'b0,
  output logic      [7:0] trig_seen = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;

  int   ph    = 0;
  logic tprev = 1'b0;

  // ==========
  // fixed-rate pulses: any slot-long window holds the same edge count
  always @(posedge mclk) begin
    ph <= (ph == PER - 1) ? 0 : ph + 1;
    count_in <= en && (ph < PER / 2);
    tprev <= pulsed_source_trigger;
    if (pulsed_source_trigger && !tprev) begin
      trig_seen <= trig_seen + 8'h01;
    end
  end
endmodule

// file: verif/pulsed_source_channel_sequencer_bench.sv
// pulsed_source_channel_sequencer_bench: one full cycle, then re-init.
// assumes the millisecond shortened to one base tick and a one-step slot width.
module pulsed_source_channel_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pscs_pkg::*;
  localparam int PER = 40;

  logic           mclk  = 1'b0;
  logic           srst  = 1'b1;
  logic [7:0]     addr  = 8'h00;
  logic [31:0]    wdata = 32'h0;
  logic           wr    = 1'b0;
  logic           rd    = 1'b0;
  logic [31:0]    rdata;
  logic           count_in;
  logic           trig;
  logic [NCH-1:0] chan_gate;
  logic           busy;
  logic           done;
  logic [7:0]     trig_seen;
  logic           g0_q  = 1'b0;
  int             err_total = 0;
  int             check_count = 0;
  int             cyc = 0;
  int             bg_starts = 0;
  int             n;

  always #25 mclk = ~mclk;

  pscs_seq #(.TICKS_PER_MS(1)) i_pscs_seq (
    .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .count_in(count_in), .pulsed_source_trigger(trig),
    .chan_gate(chan_gate), .busy(busy), .done(done));

  pscs_det_model #(.PER(PER)) i_pscs_det_model (
    .mclk(mclk), .en(1'b1), .pulsed_source_trigger(trig),
    .count_in(count_in), .trig_seen(trig_seen));

  // ==========
  // run control
  task automatic finish_test;
    $display("mismatches %0d, checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (chan_gate[0] === 1'b1 && g0_q === 1'b0) bg_starts++;
    g0_q = chan_gate[0];
    if (cyc == 95000) begin
      err_total++;
      finish_test;
    end
  end

  // ==========
  // access tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    chk(rdata, exp);
  endtask

  function automatic logic pick(input int w);
    return (w < NCH) ? chan_gate[w] : (w == NCH) ? trig : busy;
  endfunction

  // edges counted until the watched output shows v; bounded wait
  task automatic wait_on(input int w, input logic v, output int cnt);
    cnt = 0;
    do begin
      @(posedge mclk);
      cnt++;
    end while (pick(w) !== v && cnt < 50000);
    if (cnt >= 50000) begin
      err_total++;
      finish_test;
    end
  endtask

  // ==========
  // tests
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    rd_chk(REG_CFG, {16'h0, REP_HZ_RST, 2'h0, OPS_SEL_RST, 1'b0, WSEL_RST});
    rd_chk(REG_DELAY, 32'(DLY_RST));
    rd_chk(REG_OPS, 32'h0);
    rd_chk(REG_CTRL, 32'h0);
    rd_chk(8'h80, 32'h0);
    wr_reg(REG_CFG, 32'h0000a201);
    rd_chk(REG_CFG, 32'h0000a201);
    wr_reg(REG_DELAY, 32'h3);
    rd_chk(REG_DELAY, 32'(DLY_RST));
    wr_reg(REG_CTRL, 32'h3);
    rd_chk(REG_DELAY, 32'h3);
    rd_chk(REG_CTRL, 32'h2);
    wait_on(0, 1'b1, n);
    wait_on(0, 1'b0, n);
    chk(32'(n), 32'(TICK_DIV));
    wait_on(NCH, 1'b1, n);
    chk(32'(n), 32'(TICK_DIV));
    wait_on(1, 1'b1, n);
    // fire holds n-1 slots, then the ring needs one more tick
    chk(32'(n), 32'(3 * TICK_DIV));
    for (int i = 2; i < NCH; i++) begin
      wait_on(i, 1'b1, n);
      chk(32'(n), 32'(TICK_DIV));
    end
    wait_on(NCH + 1, 1'b0, n);
    chk(32'(n), 32'(TICK_DIV));
    rd_chk(REG_OPS, 32'h1);
    for (int i = 0; i < NCH; i++) begin
      rd_chk(REG_CNT0 + 8'(4 * i), 32'(TICK_DIV / PER));
    end
    chk(32'(trig_seen), 32'h1);
    wr_reg(REG_CTRL, 32'h1);
    rd_chk(REG_OPS, 32'h0);
    rd_chk(REG_CNT0, 32'h0);
    rd_chk(REG_CTRL, 32'h0);
    // longer than one repetition period with the gate closed
    repeat (41000) @(posedge mclk);
    chk(32'(bg_starts), 32'h1);
    finish_test;
  end
endmodule

bind pscs_seq pscs_seq_props i_pscs_seq_props (
  .mclk(mclk), .srst(srst), .pulsed_source_trigger(pulsed_source_trigger),
  .chan_gate(chan_gate), .busy(busy), .done(done));
